// ### rtl/sdf_pkg.sv
package sdf_pkg;
    localparam int unsigned SDF_WORD_BITS    = 16;
    localparam int unsigned SDF_NUM_OUT      = 4;
    localparam int unsigned SDF_WD_BIT       = 15;
    localparam int unsigned SDF_SEL_LSB      = 13;
    localparam int unsigned SDF_REG_LSB      = 10;
    localparam int unsigned SDF_PWM_ON_BIT   = 7;
    localparam int unsigned SDF_C1_ON_DIS    = 3;
    localparam int unsigned SDF_C1_OFF_DIS   = 2;
    localparam int unsigned SDF_C1_LED       = 1;
    localparam int unsigned SDF_C1_RATIO     = 0;
    localparam int unsigned SDF_G_SUPPLY_EN  = 8;
    localparam int unsigned SDF_G_TEMP_EN    = 5;
    localparam int unsigned SDF_G_CUR_EN     = 4;
    localparam int unsigned SDF_G_CH_LSB     = 2;
    localparam logic [6:0]  SDF_DUTY_FULL    = 7'h7F;
    localparam logic [3:0]  SDF_IDX_RST      = 4'h0;
    localparam logic [3:0]  SDF_IDX_LAST     = 4'hF;
    localparam logic [2:0]  SDF_CS_RST       = 3'h7;
    localparam int unsigned SDF_CLK_MHZ      = 200;
    localparam int unsigned SDF_LED_CHECK_US = 1000;
    localparam int unsigned SDF_LED_CHECK_CYC = SDF_LED_CHECK_US * SDF_CLK_MHZ;

    typedef enum logic [2:0] {
        SDF_REG_STATUS = 3'h0,
        SDF_REG_PWM    = 3'h1,
        SDF_REG_CONF0  = 3'h2,
        SDF_REG_CONF1  = 3'h3,
        SDF_REG_OCR    = 3'h4,
        SDF_REG_GLOBAL = 3'h5,
        SDF_REG_SPARE  = 3'h6,
        SDF_REG_CAL    = 3'h7
    } sdf_reg_t;

    typedef struct packed {
        logic [3:0] off_volt_high;
        logic [3:0] load_current_low;
        logic [3:0] direct_in;
        logic [3:0] protect_off;
        logic       temp_warn;
        logic       clamp_trip;
        logic       logic_supply_ok;
        logic       logic_supply_low;
        logic       batt_supply_ok;
        logic       por;
        logic       fail_safe;
    } sdf_sense_t;

    typedef struct packed {
        logic       on_cmd;
        logic [6:0] duty;
        logic       on_dis;
        logic       off_dis;
        logic       led_mode;
        logic       ratio;
    } sdf_out_cfg_t;

    typedef struct packed {
        logic       supply_fail_en;
        logic       temp_en;
        logic       cur_en;
        logic [1:0] channel;
        logic [4:0] status_sel;
    } sdf_glb_cfg_t;

    typedef struct packed {
        logic       temp_select;
        logic       current_active;
        logic [1:0] channel;
        logic       ratio;
    } sdf_route_t;

    localparam sdf_out_cfg_t SDF_OUT_CFG_RST = '0;
    localparam sdf_glb_cfg_t SDF_GLB_CFG_RST = '0;
    localparam sdf_sense_t   SDF_SENSE_RST   = '0;
    localparam sdf_route_t   SDF_ROUTE_RST   = '0;
endpackage

// ### rtl/sdf_frontend.sv
`timescale 1ns/1ps
// Functional notes
// - Off output with high voltage sets flag
// - Off flag clears on read once fault gone
// - Per-output disable of off open-load detection
// - Per-output LED mode selects on threshold
// - Low current on sets flag, output unchanged
// - LED check periodic, full duty, one interval
// - On flag clears on read once fault gone
// - Per-output disable of on open-load detection
// - Sense routing from enables, selector, ratio
// - Current copy off in fail-safe mode
// - Temperature warning latched, cleared by read; not latched in fail-safe
// - Supply clamp forces all outputs on
// - Logic supply loss clears written registers
// - No logic supply: outputs follow direct inputs
// - Battery loss keeps config, flags undervoltage
// - Power-on reset clears registers and faults
// - Sixteen-bit word, most significant first
// - Bit fifteen watchdog toggle monitored
// - Bits 14:13 output, 12:10 register
// - Bits 8:0 hold the register payload
// - Non-multiple-of-sixteen frames are discarded
// - Selector 00..11 addresses outputs 0..3
module sdf_frontend #(
    parameter int unsigned LED_CHECK_CYC = sdf_pkg::SDF_LED_CHECK_CYC
) (
    input  logic                 sys_clk,
    input  logic                 srst,
    input  logic                 spi_clk,
    input  logic                 spi_cs_n,
    input  logic                 spi_mosi,
    output logic                 spi_miso,
    output logic                 spi_miso_oe_n,
    input  sdf_pkg::sdf_sense_t  sense_pins,
    output logic [3:0]           switch_output,
    output logic                 fault_status_pin_n,
    output logic [3:0]           off_open_load_flag,
    output logic [3:0]           on_open_load_flag,
    output logic                 temp_prewarning_flag,
    output logic                 undervoltage_flag,
    output logic                 watchdog_fault,
    output logic                 frame_error,
    output sdf_pkg::sdf_route_t  sense_output
);
    localparam int unsigned LW = $clog2(LED_CHECK_CYC + 1);
    localparam logic [LW-1:0] LED_MAX = LW'(LED_CHECK_CYC);
    localparam logic [LW-1:0] LED_ONE = LW'(1);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Link side, clocked by the host except tx_q, which runs on sys_clk
    logic [15:0]          rx_q;
    logic [15:0]          word_q;
    logic [3:0]           idx_q;
    logic                 word_tgl_q;
    logic [14:0]          txs_q;
    logic                 miso_q;
    logic [15:0]          tx_q;

    // System side
    logic [2:0]           cs_sync_q;
    sdf_pkg::sdf_sense_t  sns_m_q;
    sdf_pkg::sdf_sense_t  sns_q;
    logic [3:0]           start_idx_q;
    logic [2:0]           tgl_sync_q;
    logic                 word_seen_q;
    logic                 cs_rise;
    logic                 cs_fall;
    logic                 frame_ok;
    logic                 rd_pulse;
    logic                 cfg_clr;
    logic                 flag_clr;
    logic [1:0]           osel;
    sdf_pkg::sdf_out_cfg_t out_cfg_q [4];
    sdf_pkg::sdf_glb_cfg_t glb_q;
    logic                 wd_last_q;
    logic                 wd_seen_q;
    logic                 wd_fault_q;
    logic                 frame_err_q;
    logic                 miso_oe_n_q;
    logic [3:0]           sw_q;
    logic [3:0]           sw_d;
    logic                 fs_n_q;
    logic [3:0]           off_ol_q;
    logic [3:0]           on_ol_q;
    logic [3:0]           cond_off;
    logic [3:0]           lvl_on;
    logic [3:0]           set_on;
    logic                 warn_q;
    logic                 uvf_q;
    sdf_pkg::sdf_route_t  route_q;
    logic [LW-1:0]        tick_cnt_q;
    logic                 tick;
    logic [LW-1:0]        on_cnt_q [4];

    function automatic logic sdf_hit(input logic ok, input logic [15:0] w,
                                     input sdf_pkg::sdf_reg_t r);
        sdf_hit = ok && (w[sdf_pkg::SDF_REG_LSB +: 3] == r);
    endfunction

    // Async clear is safe: the host clock is idle while reset is held
    always_ff @(posedge spi_clk or posedge srst)
    begin
        if (srst)
        begin
            rx_q       <= '0;
            idx_q      <= sdf_pkg::SDF_IDX_RST;
            word_tgl_q <= 1'b0;
        end
        else if (!spi_cs_n)
        begin
            rx_q  <= {rx_q[14:0], spi_mosi};
            idx_q <= idx_q + 4'h1;
            if (idx_q == sdf_pkg::SDF_IDX_LAST)
            begin
                word_tgl_q <= ~word_tgl_q;
            end
        end
    end

    // Reply word reloads at each word boundary; tx_q is frozen while framed
    always_ff @(negedge spi_clk or posedge srst)
    begin
        if (srst)
        begin
            miso_q <= 1'b0;
            txs_q  <= '0;
        end
        else if (idx_q == sdf_pkg::SDF_IDX_RST)
        begin
            miso_q <= tx_q[15];
            txs_q  <= tx_q[14:0];
        end
        else
        begin
            miso_q <= txs_q[14];
            txs_q  <= {txs_q[13:0], 1'b0};
        end
    end

    assign spi_miso = miso_q;
    // Last sixteen bits shifted, whatever the frame length
    assign word_q   = rx_q;

    // Pin synchronisers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cs_sync_q <= sdf_pkg::SDF_CS_RST;
            sns_m_q   <= sdf_pkg::SDF_SENSE_RST;
            sns_q     <= sdf_pkg::SDF_SENSE_RST;
        end
        else
        begin
            cs_sync_q <= {cs_sync_q[1:0], spi_cs_n};
            sns_m_q   <= sense_pins;
            sns_q     <= sns_m_q;
        end
    end

    assign cs_rise  = cs_sync_q[1] & ~cs_sync_q[2];
    assign cs_fall  = ~cs_sync_q[1] & cs_sync_q[2];
    // Link words are only read while the host clock is parked
    assign frame_ok = cs_rise && (idx_q == start_idx_q)
                      && word_seen_q;
    assign rd_pulse = sdf_hit(frame_ok, word_q, sdf_pkg::SDF_REG_STATUS);
    assign osel     = word_q[sdf_pkg::SDF_SEL_LSB +: 2];
    assign cfg_clr  = srst | sns_q.por | ~sns_q.logic_supply_ok
                      | (sns_q.logic_supply_low & glb_q.supply_fail_en);
    assign flag_clr = cfg_clr;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            start_idx_q <= sdf_pkg::SDF_IDX_RST;
            tgl_sync_q  <= 3'h0;
            word_seen_q <= 1'b0;
            frame_err_q <= 1'b0;
            miso_oe_n_q <= 1'b1;
        end
        else
        begin
            // Same sync depth as chip select, so the last word is seen first
            tgl_sync_q <= {tgl_sync_q[1:0], word_tgl_q};
            if (cs_fall)
            begin
                start_idx_q <= idx_q;
                word_seen_q <= 1'b0;
            end
            else if (tgl_sync_q[1] != tgl_sync_q[2])
            begin
                word_seen_q <= 1'b1;
            end
            frame_err_q <= cs_rise & ~frame_ok;
            miso_oe_n_q <= cs_sync_q[1];
        end
    end

    // Per-output and global configuration
    always_ff @(posedge sys_clk)
    begin
        if (cfg_clr)
        begin
            for (int k = 0; k < 4; k++)
            begin
                out_cfg_q[k] <= sdf_pkg::SDF_OUT_CFG_RST;
            end
            glb_q <= sdf_pkg::SDF_GLB_CFG_RST;
        end
        else
        begin
            if (sdf_hit(frame_ok, word_q, sdf_pkg::SDF_REG_PWM))
            begin
                out_cfg_q[osel].on_cmd <= word_q[sdf_pkg::SDF_PWM_ON_BIT];
                out_cfg_q[osel].duty   <= word_q[6:0];
            end
            if (sdf_hit(frame_ok, word_q, sdf_pkg::SDF_REG_CONF1))
            begin
                out_cfg_q[osel].on_dis   <= word_q[sdf_pkg::SDF_C1_ON_DIS];
                out_cfg_q[osel].off_dis  <= word_q[sdf_pkg::SDF_C1_OFF_DIS];
                out_cfg_q[osel].led_mode <= word_q[sdf_pkg::SDF_C1_LED];
                out_cfg_q[osel].ratio    <= word_q[sdf_pkg::SDF_C1_RATIO];
            end
            if (sdf_hit(frame_ok, word_q, sdf_pkg::SDF_REG_GLOBAL))
            begin
                glb_q.supply_fail_en <= word_q[sdf_pkg::SDF_G_SUPPLY_EN];
                glb_q.temp_en        <= word_q[sdf_pkg::SDF_G_TEMP_EN];
                glb_q.cur_en         <= word_q[sdf_pkg::SDF_G_CUR_EN];
                glb_q.channel        <= word_q[sdf_pkg::SDF_G_CH_LSB +: 2];
            end
            if (rd_pulse)
            begin
                glb_q.status_sel <= word_q[4:0];
            end
        end
    end

    // Watchdog bit must alternate between accepted frames
    always_ff @(posedge sys_clk)
    begin
        if (cfg_clr)
        begin
            wd_last_q  <= 1'b0;
            wd_seen_q  <= 1'b0;
            wd_fault_q <= 1'b0;
        end
        else if (frame_ok)
        begin
            wd_last_q  <= word_q[sdf_pkg::SDF_WD_BIT];
            wd_seen_q  <= 1'b1;
            wd_fault_q <= wd_seen_q && (word_q[sdf_pkg::SDF_WD_BIT] == wd_last_q);
        end
    end

    // Output drive
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            if (sns_q.clamp_trip)
            begin
                sw_d[k] = 1'b1;
            end
            else if (!sns_q.logic_supply_ok)
            begin
                sw_d[k] = sns_q.direct_in[k] & ~sns_q.protect_off[k];
            end
            else
            begin
                sw_d[k] = (out_cfg_q[k].on_cmd | sns_q.direct_in[k])
                          & ~sns_q.protect_off[k];
            end
        end
    end

    // LED check tick
    assign tick = (tick_cnt_q == LED_MAX - LED_ONE);

    always_ff @(posedge sys_clk)
    begin
        if (srst || tick)
        begin
            tick_cnt_q <= '0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + LED_ONE;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_out
            assign cond_off[gi] = ~sw_q[gi] & ~out_cfg_q[gi].off_dis
                                  & sns_q.off_volt_high[gi];
            assign lvl_on[gi]   = sw_q[gi] & ~out_cfg_q[gi].on_dis
                                  & sns_q.load_current_low[gi]
                                  & (~out_cfg_q[gi].led_mode
                                     | (out_cfg_q[gi].duty == sdf_pkg::SDF_DUTY_FULL));
            // Short pulses never reach a full interval, so they stay unchecked
            assign set_on[gi]   = lvl_on[gi] & (~out_cfg_q[gi].led_mode
                                  | (tick & (on_cnt_q[gi] == LED_MAX)));

            always_ff @(posedge sys_clk)
            begin
                if (srst || !sw_q[gi])
                begin
                    on_cnt_q[gi] <= '0;
                end
                else if (on_cnt_q[gi] != LED_MAX)
                begin
                    on_cnt_q[gi] <= on_cnt_q[gi] + LED_ONE;
                end
            end

            // Set wins over a read clear; a read only clears a vanished fault
            always_ff @(posedge sys_clk)
            begin
                if (flag_clr)
                begin
                    off_ol_q[gi] <= 1'b0;
                    on_ol_q[gi]  <= 1'b0;
                end
                else
                begin
                    if (cond_off[gi])
                    begin
                        off_ol_q[gi] <= 1'b1;
                    end
                    else if (rd_pulse)
                    begin
                        off_ol_q[gi] <= 1'b0;
                    end
                    if (set_on[gi])
                    begin
                        on_ol_q[gi] <= 1'b1;
                    end
                    else if (rd_pulse && !lvl_on[gi])
                    begin
                        on_ol_q[gi] <= 1'b0;
                    end
                end
            end

            AST_OFF_SET: assert property (cond_off[gi] && !flag_clr |=> off_ol_q[gi])
                else $error("off open-load flag not set");
            AST_OFF_HOLD: assert property (off_ol_q[gi] && cond_off[gi] && !flag_clr
                                           |=> off_ol_q[gi])
                else $error("off open-load flag cleared while fault present");
            AST_LED_GATE: assert property ($rose(on_ol_q[gi]) && out_cfg_q[gi].led_mode
                                           |-> $past(tick) && $past(on_cnt_q[gi]) == LED_MAX
                                           && $past(out_cfg_q[gi].duty) == 7'h7F)
                else $error("LED open-load flagged outside check");
            AST_ON_HOLD: assert property (on_ol_q[gi] && lvl_on[gi] && !flag_clr
                                          |=> on_ol_q[gi])
                else $error("on open-load flag lost while fault present");
        end
    endgenerate

    // Flags, routing and pins
    always_ff @(posedge sys_clk)
    begin
        if (flag_clr)
        begin
            warn_q <= 1'b0;
            uvf_q  <= 1'b0;
        end
        else
        begin
            if (!sns_q.fail_safe && sns_q.temp_warn)
            begin
                warn_q <= 1'b1;
            end
            else if (rd_pulse)
            begin
                warn_q <= 1'b0;
            end
            if (!sns_q.batt_supply_ok)
            begin
                uvf_q <= 1'b1;
            end
            else if (rd_pulse)
            begin
                uvf_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sw_q    <= 4'h0;
            fs_n_q  <= 1'b1;
            route_q <= sdf_pkg::SDF_ROUTE_RST;
            tx_q    <= '0;
        end
        else
        begin
            sw_q   <= sw_d;
            // Open load while on is kept off the fault pin
            fs_n_q <= ~(|cond_off) & sns_q.batt_supply_ok;
            route_q.temp_select    <= glb_q.temp_en;
            route_q.current_active <= glb_q.cur_en & sw_q[glb_q.channel]
                                      & ~sns_q.fail_safe;
            route_q.channel        <= glb_q.channel;
            route_q.ratio          <= out_cfg_q[glb_q.channel].ratio;
            // Reply is frozen during a frame so the flags read are pre-clear
            if (cs_sync_q[1])
            begin
                case (glb_q.status_sel[2:0])
                    3'h1:    tx_q <= {8'h00, out_cfg_q[glb_q.status_sel[4:3]].on_cmd,
                                      out_cfg_q[glb_q.status_sel[4:3]].duty};
                    3'h3:    tx_q <= {12'h000, out_cfg_q[glb_q.status_sel[4:3]].on_dis,
                                      out_cfg_q[glb_q.status_sel[4:3]].off_dis,
                                      out_cfg_q[glb_q.status_sel[4:3]].led_mode,
                                      out_cfg_q[glb_q.status_sel[4:3]].ratio};
                    default: tx_q <= {wd_last_q, uvf_q, warn_q, wd_fault_q, 4'h0,
                                      on_ol_q, off_ol_q};
                endcase
            end
        end
    end

    assign switch_output        = sw_q;
    assign fault_status_pin_n   = fs_n_q;
    assign off_open_load_flag   = off_ol_q;
    assign on_open_load_flag    = on_ol_q;
    assign temp_prewarning_flag = warn_q;
    assign undervoltage_flag    = uvf_q;
    assign watchdog_fault       = wd_fault_q;
    assign frame_error          = frame_err_q;
    assign sense_output         = route_q;
    assign spi_miso_oe_n        = miso_oe_n_q;

    AST_CLAMP_ON: assert property (sns_q.clamp_trip |=> switch_output == 4'hF)
        else $error("clamp did not force outputs on");
    AST_CUR_FAILSAFE: assert property (sns_q.fail_safe |=> !sense_output.current_active)
        else $error("current copy active in fail-safe");
    AST_SUPPLY_CLR: assert property (!sns_q.logic_supply_ok |=> glb_q == '0
                                     ##0 out_cfg_q[0] == '0 ##1 glb_q == '0)
        else $error("registers kept after logic supply loss");
    AST_FRAME_DROP: assert property (cs_rise && !frame_ok && !cfg_clr
                                     |=> glb_q == $past(glb_q) ##0 frame_error)
        else $error("bad frame altered configuration");
    AST_TEMP_WARN: assert property (!sns_q.fail_safe && sns_q.temp_warn && !flag_clr
                                    |=> temp_prewarning_flag)
        else $error("temperature warning not latched");
    AST_WD_MISS: assert property (frame_ok && wd_seen_q && word_q[15] == wd_last_q
                                  && !cfg_clr |=> watchdog_fault)
        else $error("missed watchdog toggle not flagged");
    AST_PWM_SEL: assert property (sdf_hit(frame_ok, word_q, sdf_pkg::SDF_REG_PWM) && !cfg_clr
                                  |=> out_cfg_q[$past(osel)].duty == $past(word_q[6:0]))
        else $error("duty written to wrong output");
    AST_UV_FLAG: assert property (!sns_q.batt_supply_ok && !flag_clr
                                  |=> undervoltage_flag && !fault_status_pin_n)
        else $error("battery loss not reported");

    COV_FRAME: cover property (frame_ok ##1 !frame_error);
    COV_READ_CLR: cover property (off_open_load_flag[0] && rd_pulse ##1 !off_open_load_flag[0]);
    COV_CLAMP: cover property (sns_q.clamp_trip ##1 switch_output == 4'hF);
    COV_BAD_FRAME: cover property (frame_error);
endmodule

// ### verification/sdf_host_model.sv
`timescale 1ns/1ps
// Host side of the serial link; link clock stands low outside frames
module sdf_host_model (
    output logic        spi_clk,
    output logic        spi_cs_n,
    output logic        spi_mosi,
    input  logic        spi_miso,
    input  logic        spi_miso_oe_n,
    output logic [15:0] reply
);
    initial
    begin
        spi_clk  = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        reply    = 16'h0000;
    end

    // Short frames are sent on purpose only by the refusal test
    task automatic send(input logic [31:0] w, input int n);
        int i;
        spi_cs_n = 1'b0;
        #25;
        for (i = n - 1; i >= 0; i--)
        begin
            spi_mosi = w[i];
            #7.5 spi_clk = 1'b1;
            // Undriven line seen as inverse of last bit, not a stale copy
            reply = {reply[14:0], spi_miso_oe_n ? ~reply[0] : spi_miso};
            #7.5 spi_clk = 1'b0;
        end
        #7.5 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #40;
    endtask
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [1:0] sel;
        logic [8:0] pl;
        logic [3:0] outs;
    } sdf_row_t;

    logic                sys_clk;
    logic                srst;
    logic                spi_clk;
    logic                spi_cs_n;
    logic                spi_mosi;
    logic                spi_miso;
    logic                spi_miso_oe_n;
    sdf_pkg::sdf_sense_t sense_pins;
    logic [3:0]          switch_output;
    logic                fault_status_pin_n;
    logic [3:0]          off_open_load_flag;
    logic [3:0]          on_open_load_flag;
    logic                temp_prewarning_flag;
    logic                undervoltage_flag;
    logic                watchdog_fault;
    logic                frame_error;
    sdf_pkg::sdf_route_t sense_output;
    logic                wd;
    logic                ferr_seen;
    logic [15:0]         reply;
    int                  fails;
    int                  checks_done;
    sdf_row_t            rows [6] = '{'{2'h0, 9'h080, 4'h1}, '{2'h1, 9'h080, 4'h3},
        '{2'h2, 9'h0FF, 4'h7}, '{2'h3, 9'h080, 4'hF}, '{2'h1, 9'h000, 4'hD},
        '{2'h2, 9'h07F, 4'h9}};

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    sdf_host_model host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .reply(reply));

    sdf_frontend #(.LED_CHECK_CYC(16)) i_dut (.sys_clk(sys_clk), .srst(srst),
        .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .sense_pins(sense_pins),
        .switch_output(switch_output), .fault_status_pin_n(fault_status_pin_n),
        .off_open_load_flag(off_open_load_flag), .on_open_load_flag(on_open_load_flag),
        .temp_prewarning_flag(temp_prewarning_flag), .undervoltage_flag(undervoltage_flag),
        .watchdog_fault(watchdog_fault), .frame_error(frame_error),
        .sense_output(sense_output));

    always @(posedge sys_clk)
        if (frame_error === 1'b1)
            ferr_seen <= 1'b1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Watchdog bit toggles between commands to keep the monitor quiet
    task automatic cmd(input logic [1:0] s, input logic [2:0] r, input logic [8:0] p);
        host.send({wd, s, r, 1'b0, p}, 16);
        wd = ~wd;
        settle(8);
    endtask

    task automatic results();
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        results();
    end

    initial
    begin
        srst = 1'b1;
        sense_pins = sdf_pkg::SDF_SENSE_RST;
        sense_pins.logic_supply_ok = 1'b1;
        sense_pins.batt_supply_ok = 1'b1;
        wd = 1'b0;
        ferr_seen = 1'b0;
        fails = 0;
        checks_done = 0;
        settle(6);
        chk(switch_output, 4'h0);
        chk({fault_status_pin_n, spi_miso_oe_n}, 2'h3);
        srst = 1'b0;
        settle(6);
        foreach (rows[k])
        begin
            cmd(rows[k].sel, sdf_pkg::SDF_REG_PWM, rows[k].pl);
            chk(switch_output, rows[k].outs);
        end
        cmd(2'h2, sdf_pkg::SDF_REG_CONF1, 9'h004);
        sense_pins.off_volt_high = 4'h6;
        settle(8);
        chk(off_open_load_flag, 4'h2);
        cmd(2'h0, sdf_pkg::SDF_REG_STATUS, 9'h000);
        chk(off_open_load_flag, 4'h2);
        sense_pins.off_volt_high = 4'h0;
        settle(8);
        cmd(2'h0, sdf_pkg::SDF_REG_STATUS, 9'h000);
        chk(off_open_load_flag, 4'h0);
        cmd(2'h3, sdf_pkg::SDF_REG_CONF1, 9'h008);
        sense_pins.load_current_low = 4'h9;
        settle(8);
        chk({on_open_load_flag, switch_output, fault_status_pin_n}, 9'h033);
        sense_pins.load_current_low = 4'h0;
        settle(8);
        cmd(2'h0, sdf_pkg::SDF_REG_STATUS, 9'h000);
        chk(on_open_load_flag, 4'h0);
        cmd(2'h0, sdf_pkg::SDF_REG_CONF1, 9'h002);
        cmd(2'h0, sdf_pkg::SDF_REG_PWM, 9'h0FE);
        sense_pins.load_current_low = 4'h1;
        settle(40);
        chk(on_open_load_flag, 4'h0);
        cmd(2'h0, sdf_pkg::SDF_REG_PWM, 9'h0FF);
        settle(40);
        chk(on_open_load_flag, 4'h1);
        sense_pins.temp_warn = 1'b1;
        settle(8);
        sense_pins.temp_warn = 1'b0;
        settle(8);
        chk(temp_prewarning_flag, 1'b1);
        cmd(2'h0, sdf_pkg::SDF_REG_STATUS, 9'h000);
        chk(temp_prewarning_flag, 1'b0);
        cmd(2'h0, sdf_pkg::SDF_REG_GLOBAL, 9'h01C);
        chk(sense_output, 5'h0E);
        chk(reply[14:0], 15'h2010);
        sense_pins.fail_safe = 1'b1;
        settle(8);
        chk(sense_output, 5'h06);
        sense_pins.fail_safe = 1'b0;
        sense_pins.clamp_trip = 1'b1;
        sense_pins.protect_off = 4'h9;
        settle(8);
        chk(switch_output, 4'hF);
        sense_pins.clamp_trip = 1'b0;
        sense_pins.protect_off = 4'h0;
        settle(8);
        // Daisy chain: only the last word of the frame is executed
        host.send({16'h0000, wd, 2'h1, 3'h1, 1'b0, 9'h080}, 32);
        wd = ~wd;
        settle(8);
        chk(switch_output, 4'hB);
        host.send({wd, 2'h0, 3'h1, 1'b0, 9'h000}, 15);
        settle(8);
        chk({ferr_seen, switch_output}, 5'h1B);
        wd = ~wd;
        cmd(2'h0, sdf_pkg::SDF_REG_STATUS, 9'h000);
        chk(watchdog_fault, 1'b1);
        sense_pins.batt_supply_ok = 1'b0;
        settle(8);
        chk(undervoltage_flag, 1'b1);
        sense_pins.batt_supply_ok = 1'b1;
        sense_pins.logic_supply_ok = 1'b0;
        sense_pins.direct_in = 4'h6;
        settle(8);
        chk(switch_output, 4'h6);
        sense_pins.logic_supply_ok = 1'b1;
        sense_pins.direct_in = 4'h0;
        settle(8);
        chk(switch_output, 4'h0);
        results();
    end
endmodule
